// >>> acc_front_model.sv
// Purpose: Behavioural analog front end: pins, reference and comparison
// Assumes: Levels in steps of the reference voltage over 256
// Notes:   A disabled comparator gives 0
`timescale 1ns/10ps
module acc_front_model (
    input wire acc_pkg::acc_analog_t analog_ctrl,
    input wire logic [3:0][7:0]      pos_lvl,
    input wire logic [3:0][7:0]      neg_lvl,
    output logic                     cmp_raw
);
    logic [7:0] neg_v;

    always_comb begin
        if (analog_ctrl.negative_input_select == acc_pkg::NEG_INTERNAL) begin
            neg_v = analog_ctrl.internal_reference_level;
        end else begin
            neg_v = neg_lvl[analog_ctrl.negative_input_select];
        end
        cmp_raw = analog_ctrl.enable && (pos_lvl[analog_ctrl.positive_input_select] > neg_v);
    end
endmodule : acc_front_model

// >>> acc_monitor.sv
// Purpose: Port checker for the comparator control block
// Assumes: One clock core_clk, rst_b asynchronous active low
// Notes:   Attached to every acc_top by bind
`timescale 1ns/10ps
module acc_monitor (
    input wire logic                 core_clk,
    input wire logic                 rst_b,
    input wire logic [4:0]           avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic                 avs_waitrequest,
    input wire logic [1:0]           avs_response,
    input wire acc_pkg::acc_analog_t analog_ctrl_ff,
    input wire logic                 pad_out,
    input wire logic                 pad_oe,
    input wire logic                 irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ref_reset_a: assert property ($rose(rst_b) |=> analog_ctrl_ff.internal_reference_level == 8'hff)
        else $error("reference level not ff after reset");
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered in one cycle");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    unmapped_resp_a: assert property ((avs_read || avs_write) && avs_waitrequest
        && !(avs_address inside {5'h00, 5'h04, 5'h08, 5'h10, 5'h18, 5'h1c}) |=> avs_response == 2'h2)
        else $error("unmapped access not refused");
    irq_hold_a: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest, 2))
        else $error("interrupt dropped without a register write");
    pad_needs_en_a: assert property (pad_oe |-> analog_ctrl_ff.enable)
        else $error("pad driven while comparator off");
    off_quiet_a: assert property (!analog_ctrl_ff.enable |-> !pad_out)
        else $error("pad output high while comparator off");
    cfg_stable_a: assert property ($changed(analog_ctrl_ff) && $past(rst_b, 2)
        |-> $past(avs_write && !avs_waitrequest, 2))
        else $error("analog controls changed without a write");
endmodule : acc_monitor

bind acc_top acc_monitor u_mon (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_waitrequest,
    .avs_response, .analog_ctrl_ff, .pad_out, .pad_oe, .irq);

// >>> acc_pkg.sv
// Purpose: Constants and types for the analog comparator control block
// Assumes: Avalon-MM slave, byte-wide registers on aligned 32-bit words
// Notes:   Analog comparison happens outside; this block steers and observes it
//
// Overview of operation
// - Standby-run bit keeps comparator active in standby
// - No flag set or status update while clock stopped
// - Pad enable drives comparator output to pin
// - Edge select: both, falling or rising edges
// - Low-power bit selects reduced-current comparator mode
// - Hysteresis field selects none, small, medium, large
// - Enable bit turns the comparator on
// - Invert bit inverts output for all consumers
// - Positive field routes positive pin 0 to 3
// - Negative field routes pins 0-2 or reference
// - Reference level scales reference, resets to ff
// - Interrupt enable bit gates comparator interrupt
// - Status state bit is synchronized output, three-cycle lag
// - Flag cleared by writing one, zero ignored
// - Matching output transition sets the interrupt flag
// - Request active while flag and enable set
// - Raw output high when positive exceeds negative
// - Power-down disables comparator and pad output
package acc_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [4:0] OFS_CONTROL   = 5'h00;
    localparam logic [4:0] OFS_INPUT_SEL = 5'h08;
    localparam logic [4:0] OFS_REF_LEVEL = 5'h10;
    localparam logic [4:0] OFS_INT_EN    = 5'h18;
    localparam logic [4:0] OFS_FLAGS     = 5'h1c;
    localparam logic [4:0] OFS_SLEEP     = 5'h04;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_STANDBY_RUN = 7;
    localparam int BIT_PAD_EN      = 6;
    localparam int BIT_EDGE_HI     = 5;
    localparam int BIT_EDGE_LO     = 4;
    localparam int BIT_LOW_POWER   = 3;
    localparam int BIT_HYST_HI     = 2;
    localparam int BIT_HYST_LO     = 1;
    localparam int BIT_ENABLE      = 0;
    localparam int BIT_INVERT      = 7;
    localparam int BIT_POS_HI      = 4;
    localparam int BIT_POS_LO      = 3;
    localparam int BIT_NEG_HI      = 1;
    localparam int BIT_NEG_LO      = 0;
    localparam int BIT_CMP         = 0;
    localparam int BIT_STATE       = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_INPUT_SEL = 8'h00;
    localparam logic [7:0] RST_REF_LEVEL = 8'hff;
    localparam logic [7:0] RST_INT_EN    = 8'h00;
    localparam logic [1:0] RST_SLEEP     = 2'h0;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [1:0] EDGE_ANY     = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING  = 2'h3;
    localparam logic [1:0] NEG_INTERNAL = 2'h3;

    typedef enum logic [1:0] {
        ACC_SLEEP_ACTIVE,
        ACC_SLEEP_IDLE,
        ACC_SLEEP_STANDBY,
        ACC_SLEEP_POWERDOWN
    } acc_sleep_t;

    // Analog front-end controls
    typedef struct packed {
        logic       enable;
        logic       low_power_select;
        logic [1:0] hysteresis_select;
        logic [1:0] positive_input_select;
        logic [1:0] negative_input_select;
        logic [7:0] internal_reference_level;
    } acc_analog_t;

endpackage : acc_pkg

// >>> acc_top.sv
// Purpose: Control and status logic around an analog comparator
// Assumes: core_clk 25 MHz, rst_b asynchronous active low
// Notes:   One-cycle waitrequest on every access
`timescale 1ns/10ps
module acc_top (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic [4:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    output logic      [1:0]           avs_response,
    input  wire logic                 cmp_raw,
    output acc_pkg::acc_analog_t      analog_ctrl_ff,
    output logic                      pad_out,
    output logic                      pad_oe,
    output logic                      cmp_event,
    output logic                      irq
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]  control_ff;
    logic [7:0]  input_sel_ff;
    logic [7:0]  ref_level_ff;
    logic [7:0]  int_en_ff;
    logic [1:0]  sleep_ff;
    logic        flag_ff;
    logic        sync1_ff;
    logic        sync2_ff;
    logic        state_ff;
    logic        prev_ff;
    logic        served_ff;
    logic        waitreq_ff;
    logic        pad_out_ff;
    logic        pad_oe_ff;
    logic        event_ff;
    logic        irq_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  resp_ff;

    logic        access;
    logic        wr_go;
    logic        rd_go;
    logic        clk_running;
    logic        active;
    logic        cmp_now;
    logic        edge_hit;
    logic        clr_flag;
    logic [7:0]  nxt_rdata;
    logic        nxt_ok;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d, input logic be);
        merge = be ? d[7:0] : old;
    endfunction : merge

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    assign access = avs_read | avs_write;
    assign wr_go  = avs_write & served_ff;
    assign rd_go  = avs_read & served_ff;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            served_ff  <= 1'b0;
            waitreq_ff <= 1'b1;
        end else begin
            served_ff  <= access & ~served_ff;
            waitreq_ff <= ~(access & ~served_ff);
        end
    end

    assign avs_waitrequest = waitreq_ff;
    assign avs_readdata    = rdata_ff;
    assign avs_response    = resp_ff;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_ff   <= acc_pkg::RST_CONTROL;
            input_sel_ff <= acc_pkg::RST_INPUT_SEL;
            ref_level_ff <= acc_pkg::RST_REF_LEVEL;
            int_en_ff    <= acc_pkg::RST_INT_EN;
            sleep_ff     <= acc_pkg::RST_SLEEP;
        end else if (wr_go) begin
            unique case (avs_address)
                acc_pkg::OFS_CONTROL:   control_ff   <= merge(control_ff, avs_writedata, avs_byteenable[0]);
                acc_pkg::OFS_INPUT_SEL: input_sel_ff <= merge(input_sel_ff, avs_writedata, avs_byteenable[0]) & 8'h9b;
                acc_pkg::OFS_REF_LEVEL: ref_level_ff <= merge(ref_level_ff, avs_writedata, avs_byteenable[0]);
                acc_pkg::OFS_INT_EN:    int_en_ff    <= merge(int_en_ff, avs_writedata, avs_byteenable[0]) & 8'h01;
                acc_pkg::OFS_SLEEP: begin
                    if (avs_byteenable[0]) begin
                        sleep_ff <= avs_writedata[1:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Sleep gating
    // ----------------------------------------
    assign clk_running = (sleep_ff == 2'(acc_pkg::ACC_SLEEP_ACTIVE)) ||
                         (sleep_ff == 2'(acc_pkg::ACC_SLEEP_IDLE));
    // Standby keeps comparator only with standby-run; power-down always off
    assign active = control_ff[acc_pkg::BIT_ENABLE] &
                    (clk_running |
                     ((sleep_ff == 2'(acc_pkg::ACC_SLEEP_STANDBY)) &
                      control_ff[acc_pkg::BIT_STANDBY_RUN]));

    // ----------------------------------------
    // Analog front-end controls
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            analog_ctrl_ff <= '0;
        end else begin
            analog_ctrl_ff.enable                   <= active;
            analog_ctrl_ff.low_power_select         <= control_ff[acc_pkg::BIT_LOW_POWER];
            analog_ctrl_ff.hysteresis_select        <= control_ff[acc_pkg::BIT_HYST_HI:acc_pkg::BIT_HYST_LO];
            analog_ctrl_ff.positive_input_select    <= input_sel_ff[acc_pkg::BIT_POS_HI:acc_pkg::BIT_POS_LO];
            analog_ctrl_ff.negative_input_select    <= input_sel_ff[acc_pkg::BIT_NEG_HI:acc_pkg::BIT_NEG_LO];
            analog_ctrl_ff.internal_reference_level <= ref_level_ff;
        end
    end

    // ----------------------------------------
    // Output path (raw high when positive above negative)
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_out_ff <= 1'b0;
            pad_oe_ff  <= 1'b0;
            event_ff   <= 1'b0;
        end else begin
            pad_out_ff <= (sync2_ff ^ input_sel_ff[acc_pkg::BIT_INVERT]) & active;
            pad_oe_ff  <= control_ff[acc_pkg::BIT_PAD_EN] & active;
            event_ff   <= (sync2_ff ^ input_sel_ff[acc_pkg::BIT_INVERT]) & active;
        end
    end

    assign pad_out   = pad_out_ff;
    assign pad_oe    = pad_oe_ff;
    assign cmp_event = event_ff;

    // ----------------------------------------
    // Synchronizer and state
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= cmp_raw;
            sync2_ff <= sync1_ff;
        end
    end

    assign cmp_now = (sync2_ff ^ input_sel_ff[acc_pkg::BIT_INVERT]) & active;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else if (clk_running) begin
            state_ff <= cmp_now;
            prev_ff  <= cmp_now;
        end
    end

    // ----------------------------------------
    // Edge detect and interrupt flag
    // ----------------------------------------
    always_comb begin
        unique case (control_ff[acc_pkg::BIT_EDGE_HI:acc_pkg::BIT_EDGE_LO])
            acc_pkg::EDGE_ANY:     edge_hit = cmp_now ^ prev_ff;
            acc_pkg::EDGE_FALLING: edge_hit = ~cmp_now & prev_ff;
            acc_pkg::EDGE_RISING:  edge_hit = cmp_now & ~prev_ff;
            default:               edge_hit = 1'b0;
        endcase
    end

    assign clr_flag = wr_go && (avs_address == acc_pkg::OFS_FLAGS) && avs_byteenable[0] &&
                      avs_writedata[acc_pkg::BIT_CMP];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff <= 1'b0;
        end else if (clk_running && edge_hit) begin
            flag_ff <= 1'b1;
        end else if (clr_flag) begin
            flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff & int_en_ff[acc_pkg::BIT_CMP];
        end
    end

    assign irq = irq_ff;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 8'h00;
        nxt_ok    = 1'b1;
        unique case (avs_address)
            acc_pkg::OFS_CONTROL:   nxt_rdata = control_ff;
            acc_pkg::OFS_INPUT_SEL: nxt_rdata = input_sel_ff;
            acc_pkg::OFS_REF_LEVEL: nxt_rdata = ref_level_ff;
            acc_pkg::OFS_INT_EN:    nxt_rdata = int_en_ff;
            acc_pkg::OFS_SLEEP:     nxt_rdata = {6'h00, sleep_ff};
            acc_pkg::OFS_FLAGS: begin
                nxt_rdata[acc_pkg::BIT_STATE] = state_ff;
                nxt_rdata[acc_pkg::BIT_CMP]   = flag_ff;
            end
            default:                nxt_ok    = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h0000_0000;
            resp_ff  <= 2'h0;
        end else if (access & ~served_ff) begin
            rdata_ff <= avs_read ? {24'h000000, nxt_rdata} : 32'h0000_0000;
            resp_ff  <= nxt_ok ? 2'h0 : 2'h2;
        end
    end

endmodule : acc_top

// >>> acc_top_bench.sv
// Purpose: Self-checking bench for the comparator control block
// Assumes: Bus tasks wait for waitrequest low, then release
// Notes:   Front-end model closes the comparator loop
`timescale 1ns/10ps
module acc_top_bench;
    logic                core_clk, rst_b, avs_read, avs_write, avs_waitrequest, cmp_raw, pad_out, pad_oe, irq;
    logic                cmp_event;
    logic [4:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata;
    logic [1:0]          avs_response, rsp_q;
    logic [7:0]          rd_q;
    logic [3:0][7:0]     pos_lvl, neg_lvl;
    acc_pkg::acc_analog_t analog_ctrl_ff;
    int                  bad_count, num_checks;

    acc_top u_dut (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .avs_response, .cmp_raw,
        .analog_ctrl_ff, .pad_out, .pad_oe, .cmp_event, .irq);
    acc_front_model u_front (.analog_ctrl(analog_ctrl_ff), .pos_lvl, .neg_lvl, .cmp_raw);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_op(input logic [4:0] a, input logic wr, input logic [7:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata[7:0];
        rsp_q = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_op

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_op(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        bus_op(a, 1'b0, 8'h00);
        chk(rd_q, exp);
    endtask : rd

    task automatic settle();
        repeat (8) @(negedge core_clk);
    endtask : settle

    task automatic t_regs();
        rd(5'h00, 8'h00);
        rd(5'h08, 8'h00);
        rd(5'h10, 8'hff);
        rd(5'h18, 8'h00);
        rd(5'h1c, 8'h00);
        rd(5'h14, 8'h00);
        chk({6'h0, rsp_q}, 8'h02);
        wr(5'h08, 8'hff);
        rd(5'h08, 8'h9b);
        wr(5'h18, 8'hff);
        rd(5'h18, 8'h01);
        $display("end of test regs");
    endtask : t_regs

    task automatic t_cfg();
        for (int i = 0; i < 4; i++) begin
            wr(5'h00, {4'h0, i[0], i[1:0], 1'b1});
            wr(5'h08, {3'h0, i[1:0], 1'b0, i[1:0]});
            settle();
            chk({analog_ctrl_ff.enable, analog_ctrl_ff.low_power_select, analog_ctrl_ff.hysteresis_select,
                analog_ctrl_ff.positive_input_select, analog_ctrl_ff.negative_input_select},
                {1'b1, i[0], i[1:0], i[1:0], i[1:0]});
        end
        $display("end of test cfg");
    endtask : t_cfg

    task automatic t_edges();
        logic rise_hit, fall_hit;
        wr(5'h08, 8'h00);
        for (int k = 0; k < 4; k++) begin
            rise_hit = (k == 0 || k == 3);
            fall_hit = (k == 0 || k == 2);
            wr(5'h00, {2'h0, k[1:0], 4'h1});
            wr(5'h1c, 8'h01);
            pos_lvl[0] <= 8'h30;
            settle();
            rd(5'h1c, {7'h08, rise_hit});
            chk({7'h0, irq}, {7'h0, rise_hit});
            wr(5'h1c, 8'h00);
            rd(5'h1c, {7'h08, rise_hit});
            wr(5'h1c, 8'h01);
            pos_lvl[0] <= 8'h10;
            settle();
            rd(5'h1c, {7'h00, fall_hit});
            wr(5'h1c, 8'h01);
        end
        $display("end of test edges");
    endtask : t_edges

    task automatic t_invert_ref_sleep();
        wr(5'h00, 8'h61);
        wr(5'h08, 8'h80);
        settle();
        rd(5'h1c, 8'h10);
        chk({5'h0, cmp_event, pad_oe, pad_out}, 8'h07);
        wr(5'h10, 8'h08);
        wr(5'h08, 8'h03);
        settle();
        rd(5'h1c, 8'h11);
        wr(5'h04, 8'h02);
        settle();
        chk({6'h0, analog_ctrl_ff.enable, pad_oe}, 8'h00);
        wr(5'h00, 8'he1);
        settle();
        chk({6'h0, analog_ctrl_ff.enable, pad_oe}, 8'h03);
        wr(5'h04, 8'h03);
        settle();
        chk({6'h0, analog_ctrl_ff.enable, pad_oe}, 8'h00);
        $display("end of test invert_ref_sleep");
    endtask : t_invert_ref_sleep

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        pos_lvl = {4{8'h10}};
        neg_lvl = {4{8'h20}};
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs();
        t_cfg();
        t_edges();
        t_invert_ref_sleep();
        end_of_test();
    end
endmodule : acc_top_bench
